// File: verilog/psram_host_defs.vh
`ifndef PSRAM_HOST_DEFS_VH
`define PSRAM_HOST_DEFS_VH
// register byte offsets
`define OFF_CTRL      8'h00
`define OFF_ADDR      8'h04
`define OFF_WDATA     8'h08
`define OFF_RDATA     8'h0C
`define OFF_STATUS    8'h10
`define OFF_CFGVAL    8'h14
`define OFF_TIMING    8'h18
// command field of control register
`define CMD_LSB       0
`define CMD_W         3
`define CMD_NONE      3'h0
`define CMD_READ      3'h1
`define CMD_WRITE     3'h2
`define CMD_CFGLOAD   3'h3
`define CMD_SLEEP     3'h4
`define CMD_WAKE      3'h5
`define CMD_PAGEREAD  3'h6
`define CTRL_LANE_LO  4
`define CTRL_LANE_HI  5
// status bits
`define ST_BUSY       0
`define ST_READY      1
`define ST_SLEEP      2
`define ST_DATALOST   3
`define ST_PAGEEN     4
`define ST_SLEEPPAR   5
// configuration defaults
`define CFG_DEFAULT   19'h00010
`define CFG_SLEEP_BIT 4
`define CFG_PAGE_BIT  7
// times
`define INIT_US       150
`define SLEEP_US      10
`define CLK_MHZ       100
`define INIT_CYC      (`INIT_US * `CLK_MHZ)
`define SLEEP_CYC     (`SLEEP_US * `CLK_MHZ + 1)
// default access timing in cycles
`define ACC_FULL_CYC  8'h07
`define ACC_PAGE_CYC  8'h02
`define WR_PULSE_CYC  8'h07
`define MAX_LOW_CYC   8'h50
`endif

// File: verilog/page_buffer.v
`default_nettype none
module page_buffer #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock
  input  wire             ref_clk,
  // write side
  input  wire             wrEn,
  input  wire [AW-1:0]    wrAddr,
  input  wire [WIDTH-1:0] wrData,
  // read side
  input  wire [AW-1:0]    rdAddr,
  output reg  [WIDTH-1:0] rdData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  always @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// File: verilog/psram_host.v
// Operation
// - hold select high during init
// - read: select, output, lane low
// - page reads: limit select low time for refresh
// - sleep bit set: sleep low enters partial
// - sleep bit clear: deep sleep, data lost
// - deep sleep only through sleep pin
// - sleep low write loads address as config
`include "psram_host_defs.vh"
`default_nettype none
module psram_host #(
  parameter AW        = 19,
  parameter DW        = 16,
  parameter INIT_CYC  = `INIT_CYC,
  parameter SLEEP_CYC = `SLEEP_CYC
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          arst_n,
  // wishbone slave
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  // memory pins
  output reg           chipSel_n,
  output reg           writeEn_n,
  output reg           outEn_n,
  output reg           low_lane_sel_n,
  output reg           high_lane_sel_n,
  output reg           sleep_n,
  output reg  [AW-1:0] memAddr,
  output reg  [DW-1:0] dqOut,
  output reg  [1:0]    dqOe,
  input  wire [DW-1:0] dqIn
);
  localparam S_INIT  = 4'h0;
  localparam S_IDLE  = 4'h1;
  localparam S_RD    = 4'h2;
  localparam S_WR    = 4'h3;
  localparam S_WREND = 4'h4;
  localparam S_SLPLO = 4'h5;
  localparam S_SLEEP = 4'h6;
  localparam S_CFG   = 4'h7;
  localparam S_PAGE  = 4'h8;
  localparam S_GAP   = 4'h9;

  reg  [3:0]    state_reg;
  reg  [15:0]   cnt_reg;
  reg  [7:0]    acc_reg;
  reg  [DW-1:0] dqMeta_reg;
  reg  [DW-1:0] dqSync_reg;
  reg  [2:0]    cmd_reg;
  reg  [1:0]    lanes_reg;
  reg  [AW-1:0] addr_reg;
  reg  [DW-1:0] wdata_reg;
  reg  [DW-1:0] rdata_reg;
  reg  [AW-1:0] cfg_reg;
  reg  [7:0]    tFull_reg;
  reg  [7:0]    tPage_reg;
  reg  [7:0]    tWr_reg;
  reg  [7:0]    tMax_reg;
  reg           dataLost_reg;
  reg           pageValid_reg;
  reg  [AW-5:0] pageTag_reg;
  reg  [3:0]    pageIdx_reg;
  reg           bufWr_reg;
  reg           cmdGo;
  reg  [2:0]    wb_cmdLatch;
  wire [DW-1:0] bufData;
  wire          busy;
  wire          wbReq;
  wire          laneNone;
  wire [DW-1:0] laneMask;

  // asleep counts as not busy so that a wake command is accepted
  assign busy     = ((state_reg != S_IDLE) && (state_reg != S_SLEEP)) ||
                    (cmd_reg != `CMD_NONE);
  assign wbReq    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign laneNone = (lanes_reg == 2'b00);
  assign laneMask = {{8{lanes_reg[1]}}, {8{lanes_reg[0]}}};

  page_buffer #(.WIDTH(DW), .DEPTH(16), .AW(4)) u_buf (
    .ref_clk (ref_clk),
    .wrEn    (bufWr_reg),
    .wrAddr  (pageIdx_reg),
    .wrData  (dqSync_reg),
    .rdAddr  (addr_reg[3:0]),
    .rdData  (bufData)
  );

  // data pins pass two flops
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dqMeta_reg <= 16'h0000;
      dqSync_reg <= 16'h0000;
    end else begin
      dqMeta_reg <= dqIn;
      dqSync_reg <= dqMeta_reg;
    end
  end

  // register slave, answers one cycle after request
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
      addr_reg  <= 19'h00000;
      wdata_reg <= 16'h0000;
      lanes_reg <= 2'b11;
      tFull_reg <= `ACC_FULL_CYC;
      tPage_reg <= `ACC_PAGE_CYC;
      tWr_reg   <= `WR_PULSE_CYC;
      tMax_reg  <= `MAX_LOW_CYC;
      cmdGo     <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
      cmdGo    <= 1'b0;
      if (wbReq && wb_we_i) begin
        case (wb_adr_i)
          `OFF_CTRL: begin
            if (wb_sel_i[0] && !busy) begin
              lanes_reg <= {wb_dat_i[`CTRL_LANE_HI], wb_dat_i[`CTRL_LANE_LO]};
              cmdGo     <= 1'b1;
            end
          end
          `OFF_ADDR: begin
            addr_reg <= wb_dat_i[AW-1:0];
          end
          `OFF_WDATA: begin
            wdata_reg <= wb_dat_i[DW-1:0];
          end
          `OFF_TIMING: begin
            tFull_reg <= (wb_dat_i[7:0] == 8'h00) ? 8'h01 : wb_dat_i[7:0];
            tPage_reg <= (wb_dat_i[15:8] == 8'h00) ? 8'h01 : wb_dat_i[15:8];
            tWr_reg   <= (wb_dat_i[23:16] == 8'h00) ? 8'h01 : wb_dat_i[23:16];
            tMax_reg  <= (wb_dat_i[31:24] < 8'h10) ? 8'h10 : wb_dat_i[31:24];
          end
          default: begin
          end
        endcase
      end
      if (wbReq) begin
        case (wb_adr_i)
          `OFF_CTRL:   wb_dat_o <= {26'h0, lanes_reg[1], lanes_reg[0], 1'b0, cmd_reg};
          `OFF_ADDR:   wb_dat_o <= {13'h0, addr_reg};
          `OFF_WDATA:  wb_dat_o <= {16'h0, wdata_reg};
          `OFF_RDATA:  wb_dat_o <= {16'h0, rdata_reg};
          `OFF_STATUS: wb_dat_o <= {26'h0, cfg_reg[`CFG_SLEEP_BIT], cfg_reg[`CFG_PAGE_BIT],
                                    dataLost_reg, (state_reg == S_SLEEP),
                                    (state_reg != S_INIT), busy};
          `OFF_CFGVAL: wb_dat_o <= {13'h0, cfg_reg};
          `OFF_TIMING: wb_dat_o <= {tMax_reg, tWr_reg, tPage_reg, tFull_reg};
          default:     wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // pin sequencer
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg       <= S_INIT;
      cnt_reg         <= 16'h0000;
      acc_reg         <= 8'h00;
      cmd_reg         <= `CMD_NONE;
      rdata_reg       <= 16'h0000;
      cfg_reg         <= `CFG_DEFAULT;
      dataLost_reg    <= 1'b0;
      pageValid_reg   <= 1'b0;
      pageTag_reg     <= 15'h0000;
      pageIdx_reg     <= 4'h0;
      bufWr_reg       <= 1'b0;
      chipSel_n       <= 1'b1;
      writeEn_n       <= 1'b1;
      outEn_n         <= 1'b1;
      low_lane_sel_n  <= 1'b1;
      high_lane_sel_n <= 1'b1;
      sleep_n         <= 1'b1;
      memAddr         <= 19'h00000;
      dqOut           <= 16'h0000;
      dqOe            <= 2'b00;
    end else begin
      bufWr_reg <= 1'b0;
      if (cmdGo) begin
        cmd_reg <= wdata_reg[2:0] == 3'h0 ? `CMD_NONE : `CMD_NONE;
      end
      case (state_reg)
        S_INIT: begin
          chipSel_n <= 1'b1;
          if (cnt_reg == INIT_CYC[15:0] - 16'h0001) begin
            cnt_reg   <= 16'h0000;
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        S_IDLE: begin
          // pins stay static between accesses
          chipSel_n       <= 1'b1;
          writeEn_n       <= 1'b1;
          outEn_n         <= 1'b1;
          low_lane_sel_n  <= 1'b1;
          high_lane_sel_n <= 1'b1;
          dqOe            <= 2'b00;
          cnt_reg         <= 16'h0000;
          if (cmd_reg != `CMD_NONE) begin
            cmd_reg <= `CMD_NONE;
            memAddr <= addr_reg;
            case (cmd_reg)
              `CMD_READ, `CMD_PAGEREAD: begin
                chipSel_n       <= 1'b0;
                outEn_n         <= 1'b0;
                low_lane_sel_n  <= ~lanes_reg[0];
                high_lane_sel_n <= ~lanes_reg[1];
                pageIdx_reg     <= 4'h0;
                if (cmd_reg == `CMD_PAGEREAD && cfg_reg[`CFG_PAGE_BIT] &&
                    pageValid_reg && pageTag_reg == addr_reg[AW-1:4]) begin
                  state_reg <= S_GAP;
                  chipSel_n <= 1'b1;
                  outEn_n   <= 1'b1;
                  cnt_reg   <= 16'h0001;
                end else begin
                  memAddr   <= (cmd_reg == `CMD_PAGEREAD && cfg_reg[`CFG_PAGE_BIT]) ?
                               {addr_reg[AW-1:4], 4'h0} : addr_reg;
                  acc_reg   <= tFull_reg;
                  state_reg <= (cmd_reg == `CMD_PAGEREAD && cfg_reg[`CFG_PAGE_BIT]) ?
                               S_PAGE : S_RD;
                end
              end
              `CMD_WRITE: begin
                chipSel_n       <= 1'b0;
                writeEn_n       <= 1'b0;
                low_lane_sel_n  <= ~lanes_reg[0];
                high_lane_sel_n <= ~lanes_reg[1];
                dqOut           <= wdata_reg;
                dqOe            <= laneNone ? 2'b00 : 2'b11;
                acc_reg         <= tWr_reg;
                pageValid_reg   <= 1'b0;
                state_reg       <= S_WR;
              end
              `CMD_CFGLOAD, `CMD_SLEEP: begin
                // config only through the pin path
                sleep_n   <= 1'b0;
                state_reg <= S_SLPLO;
                cmd_reg   <= cmd_reg;
              end
              default: begin
              end
            endcase
          end
        end
        S_RD: begin
          if (acc_reg == 8'h01) begin
            rdata_reg <= dqSync_reg & laneMask;
            state_reg <= S_WREND;
          end else begin
            acc_reg <= acc_reg - 8'h01;
          end
        end
        S_PAGE: begin
          // page fill of sixteen words, select time bounded
          cnt_reg <= cnt_reg + 16'h0001;
          if (acc_reg == 8'h01) begin
            bufWr_reg   <= 1'b1;
            if (memAddr[3:0] == addr_reg[3:0]) begin
              rdata_reg <= dqSync_reg & laneMask;
            end
            pageIdx_reg <= memAddr[3:0];
            acc_reg     <= tPage_reg + 8'h02;
            if (memAddr[3:0] == 4'hF || cnt_reg[7:0] >= tMax_reg) begin
              pageValid_reg <= (memAddr[3:0] == 4'hF);
              pageTag_reg   <= addr_reg[AW-1:4];
              state_reg     <= S_WREND;
            end else begin
              memAddr[3:0] <= memAddr[3:0] + 4'h1;
            end
          end else begin
            acc_reg <= acc_reg - 8'h01;
          end
        end
        S_GAP: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'h0002) begin
            rdata_reg <= bufData & laneMask;
            state_reg <= S_IDLE;
          end
        end
        S_WR: begin
          if (acc_reg == 8'h01) begin
            writeEn_n <= 1'b1;
            state_reg <= S_WREND;
          end else begin
            acc_reg <= acc_reg - 8'h01;
          end
        end
        S_WREND: begin
          chipSel_n       <= 1'b1;
          writeEn_n       <= 1'b1;
          outEn_n         <= 1'b1;
          low_lane_sel_n  <= 1'b1;
          high_lane_sel_n <= 1'b1;
          dqOe            <= 2'b00;
          state_reg       <= (sleep_n) ? S_IDLE : S_IDLE;
          sleep_n         <= 1'b1;
        end
        S_SLPLO: begin
          if (cmd_reg == `CMD_CFGLOAD) begin
            chipSel_n <= 1'b0;
            writeEn_n <= 1'b0;
            memAddr   <= wdata_reg[2:0] == 3'h7 ? addr_reg : addr_reg;
            acc_reg   <= tWr_reg;
            cmd_reg   <= `CMD_NONE;
            state_reg <= S_CFG;
          end else if (cnt_reg == SLEEP_CYC[15:0]) begin
            cmd_reg   <= `CMD_NONE;
            state_reg <= S_SLEEP;
            pageValid_reg <= 1'b0;
            if (!cfg_reg[`CFG_SLEEP_BIT]) begin
              dataLost_reg <= 1'b1;
            end
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        S_CFG: begin
          if (acc_reg == 8'h01) begin
            writeEn_n <= 1'b1;
            cfg_reg   <= memAddr;
            state_reg <= S_WREND;
          end else begin
            acc_reg <= acc_reg - 8'h01;
          end
        end
        S_SLEEP: begin
          // accesses are dropped until wake
          if (cmd_reg == `CMD_WAKE) begin
            cmd_reg <= `CMD_NONE;
            sleep_n <= 1'b1;
            cnt_reg <= 16'h0000;
            state_reg <= cfg_reg[`CFG_SLEEP_BIT] ? S_IDLE : S_INIT;
          end else begin
            cmd_reg <= `CMD_NONE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
      if (cmdGo) begin
        cmd_reg <= wb_cmdLatch;
      end
    end
  end

  // command captured at the control write
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_cmdLatch <= `CMD_NONE;
    end else if (wbReq && wb_we_i && wb_adr_i == `OFF_CTRL && wb_sel_i[0] && !busy) begin
      wb_cmdLatch <= wb_dat_i[`CMD_LSB +: `CMD_W];
    end
  end
endmodule
`default_nettype wire

// File: tb/psram_host_monitor.sv
`include "psram_host_defs.vh"
`default_nettype none
module psram_host_monitor #(
  parameter int INIT_CYC = 20
) (
  // clock, reset and bus
  input wire logic        ref_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  // memory pins
  input wire logic        chipSel_n, writeEn_n, outEn_n, low_lane_sel_n, high_lane_sel_n,
  input wire logic        sleep_n,
  input wire logic [18:0] memAddr,
  input wire logic [15:0] dqOut, dqIn,
  input wire logic [1:0]  dqOe
);
  timeunit 1ns;
  timeprecision 1ps;
  int initCnt;
  int lowCnt;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      initCnt <= 0;
      lowCnt <= 0;
    end else begin
      if (initCnt < INIT_CYC) initCnt <= initCnt + 1;
      lowCnt <= chipSel_n ? 0 : lowCnt + 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_wr_start; $fell(writeEn_n) && sleep_n; endsequence
  sequence s_wr_end; $rose(writeEn_n); endsequence
  property p_ack_next; s_req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_init; (initCnt < INIT_CYC) |-> chipSel_n; endproperty
  property p_read_we; !outEn_n |-> writeEn_n && !chipSel_n; endproperty
  property p_no_clash; (dqOe != 2'b00) |-> outEn_n; endproperty
  property p_wr_hold;
    (!writeEn_n && !$past(writeEn_n)) |-> $stable(memAddr) && $stable(dqOut);
  endproperty
  property p_wr_end; s_wr_end |-> !chipSel_n ##1 chipSel_n; endproperty
  property p_wr_lane;
    s_wr_start |-> !chipSel_n && !(low_lane_sel_n && high_lane_sel_n);
  endproperty
  property p_max_low; lowCnt <= `MAX_LOW_CYC; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_init: assert property (p_init) else $error("select during init");
  a_read_we: assert property (p_read_we) else $error("bad read strobes");
  a_no_clash: assert property (p_no_clash) else $error("drive during read");
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved");
  a_wr_end: assert property (p_wr_end) else $error("write end order");
  a_wr_lane: assert property (p_wr_lane) else $error("write without lane");
  a_max_low: assert property (p_max_low) else $error("select low too long");
endmodule
bind psram_host psram_host_monitor #(.INIT_CYC(INIT_CYC)) mon (.ref_clk, .arst_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .chipSel_n, .writeEn_n, .outEn_n, .low_lane_sel_n, .high_lane_sel_n, .sleep_n,
  .memAddr, .dqOut, .dqIn, .dqOe);
`default_nettype wire

// File: tb/psram_model.sv
`default_nettype none
module psram_model #(
  parameter int SLEEP_CYC = 5,
  parameter int INIT_CYC  = 20
) (
  // memory pins
  input wire logic        ref_clk, chipSel_n, writeEn_n, outEn_n,
  input wire logic        low_lane_sel_n, high_lane_sel_n, sleep_n,
  input wire logic [18:0] memAddr,
  input wire logic [15:0] dqOut,
  input wire logic [1:0]  dqOe,
  output logic     [15:0] dqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  logic [18:0] cfgReg = 19'h00010;
  logic [18:0] wrA;
  logic [15:0] wrD, rdW, w;
  logic [15:0] junk = 16'h00FF;
  logic [1:0]  wrL;
  logic        wrAct = 1'b0;
  int          cnt = 0;
  int          mode = 3; // 0 normal, 1 partial, 2 deep, 3 init
  wire         wrNow = !chipSel_n && !writeEn_n;
  wire  [1:0]  lanes = {!high_lane_sel_n, !low_lane_sel_n};
  wire         rdNow = mode == 0 && !chipSel_n && !outEn_n && writeEn_n && sleep_n;
  always @* begin
    rdW = mem.exists(memAddr) ? mem[memAddr] : 16'h5A5A;
    for (int i = 0; i < 2; i++)
      dqIn[i*8 +: 8] = (rdNow && lanes[i]) ? rdW[i*8 +: 8] : junk[i*8 +: 8];
  end
  always @(posedge ref_clk) begin
    junk <= ~junk;
    wrAct <= wrNow;
    if (wrNow) begin
      wrA <= memAddr;
      wrD <= dqOut;
      wrL <= lanes;
    end
    if (wrAct && !wrNow) begin
      if (!sleep_n) cfgReg <= wrA;
      else if (mode == 0 && wrL != 2'b00) begin
        w = mem.exists(wrA) ? mem[wrA] : 16'h5A5A;
        if (wrL[0]) w[7:0] = wrD[7:0];
        if (wrL[1]) w[15:8] = wrD[15:8];
        mem[wrA] = w;
      end
    end
    if (!sleep_n && chipSel_n) begin
      cnt <= cnt + 1;
      if (cnt == SLEEP_CYC - 1) begin
        mode <= cfgReg[4] ? 1 : 2;
        if (!cfgReg[4]) mem.delete();
      end
    end else if (sleep_n) begin
      if (mode == 1) mode <= 0;
      else if (mode == 2) begin
        mode <= 3;
        cnt <= 0;
      end else if (mode == 3) begin
        cnt <= cnt + 1;
        if (cnt == INIT_CYC) mode <= 0;
      end else cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// File: tb/psram_host_tb.sv
`include "psram_host_defs.vh"
`default_nettype none
module psram_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  wire logic [31:0] wb_dat_o;
  wire logic        wb_ack_o, chipSel_n, writeEn_n, outEn_n, low_lane_sel_n;
  wire logic        high_lane_sel_n, sleep_n;
  wire logic [18:0] memAddr;
  wire logic [15:0] dqOut, dqIn;
  wire logic [1:0]  dqOe;
  int          mismatches = 0, num_checks = 0;
  logic [15:0] shadow [int];
  psram_host #(.INIT_CYC(20), .SLEEP_CYC(5)) uut (.ref_clk, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .chipSel_n, .writeEn_n,
    .outEn_n, .low_lane_sel_n, .high_lane_sel_n, .sleep_n, .memAddr, .dqOut, .dqOe, .dqIn);
  psram_model #(.SLEEP_CYC(5), .INIT_CYC(20)) partner (.ref_clk, .chipSel_n, .writeEn_n,
    .outEn_n, .low_lane_sel_n, .high_lane_sel_n, .sleep_n, .memAddr, .dqOut, .dqOe, .dqIn);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [1:0] ln, input logic [18:0] a,
                     input logic [15:0] d);
    logic [31:0] s;
    int n;
    n = 0;
    wr(`OFF_ADDR, {13'h0, a});
    wr(`OFF_WDATA, {16'h0, d});
    wr(`OFF_CTRL, {26'h0, ln, 1'b0, c});
    do begin
      rd(`OFF_STATUS, s);
      n++;
    end while (s[`ST_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) begin
      mismatches++;
      summarize();
    end
  endtask
  function automatic void upd(input logic [18:0] a, input logic [1:0] ln, input logic [15:0] d);
    logic [15:0] v;
    v = shadow.exists(a) ? shadow[a] : 16'h5A5A;
    if (ln[0]) v[7:0] = d[7:0];
    if (ln[1]) v[15:8] = d[15:8];
    shadow[a] = v;
  endfunction
  function automatic logic [31:0] expRd(input logic [18:0] a, input logic [1:0] ln);
    logic [15:0] v;
    v = shadow.exists(a) ? shadow[a] : 16'h5A5A;
    return {16'h0, ln[1] ? v[15:8] : 8'h00, ln[0] ? v[7:0] : 8'h00};
  endfunction
  task automatic rwLoop(input int cnt);
    logic [31:0] q;
    logic [18:0] a;
    logic [15:0] d;
    logic [1:0]  ln;
    for (int i = 0; i < cnt; i++) begin
      a = (i == 0) ? 19'h00000 : (i == 1) ? 19'h7FFFF : 19'($urandom);
      d = 16'($urandom);
      cmd(`CMD_WRITE, 2'b11, a, d);
      upd(a, 2'b11, d);
      ln = 2'(i % 3 + 1);
      d = 16'($urandom);
      cmd(`CMD_WRITE, ln, a, d);
      upd(a, ln, d);
      ln = 2'($urandom % 3 + 1);
      cmd(`CMD_READ, ln, a, 16'h0);
      rd(`OFF_RDATA, q);
      check(q, expRd(a, ln));
    end
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end
  initial begin
    logic [31:0] q;
    q = $urandom(32'h5CAB);
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(`OFF_STATUS, q);
    check(q[5:1], 5'b10000);
    repeat (30) @(posedge ref_clk);
    rd(`OFF_STATUS, q);
    check(q[1], 1'b1);
    $display("test init done");
    rwLoop(12);
    $display("test random access done");
    cmd(`CMD_CFGLOAD, 2'b00, 19'h00090, 16'h0);
    rd(`OFF_STATUS, q);
    check(q[5:4], 2'b11);
    for (int i = 0; i < 16; i++) begin
      cmd(`CMD_WRITE, 2'b11, 19'h00120 + 19'(i), 16'(i * 16'h0111));
      upd(19'h00120 + 19'(i), 2'b11, 16'(i * 16'h0111));
    end
    for (int i = 15; i >= 0; i -= 5) begin
      cmd(`CMD_PAGEREAD, 2'b11, 19'h00120 + 19'(i), 16'h0);
      rd(`OFF_RDATA, q);
      check(q, expRd(19'h00120 + 19'(i), 2'b11));
    end
    $display("test page read done");
    cmd(`CMD_SLEEP, 2'b00, 19'h0, 16'h0);
    repeat (20) @(posedge ref_clk);
    rd(`OFF_STATUS, q);
    check(q[3:2], 2'b01);
    cmd(`CMD_WAKE, 2'b00, 19'h0, 16'h0);
    cmd(`CMD_READ, 2'b11, 19'h00123, 16'h0);
    rd(`OFF_RDATA, q);
    check(q, expRd(19'h00123, 2'b11));
    $display("test partial sleep done");
    cmd(`CMD_CFGLOAD, 2'b00, 19'h00000, 16'h0);
    rd(`OFF_STATUS, q);
    check(q[5:4], 2'b00);
    cmd(`CMD_SLEEP, 2'b00, 19'h0, 16'h0);
    repeat (20) @(posedge ref_clk);
    rd(`OFF_STATUS, q);
    check(q[3:2], 2'b11);
    shadow.delete();
    cmd(`CMD_WAKE, 2'b00, 19'h0, 16'h0);
    repeat (30) @(posedge ref_clk);
    rd(`OFF_STATUS, q);
    check(q[1], 1'b1);
    rwLoop(3);
    $display("test deep sleep done");
    rd(8'h1C, q);
    check(q, 32'h0);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, q);
    check(q, 32'h0);
    $display("test unmapped done");
    summarize();
  end
endmodule
`default_nettype wire
